// [mbpa_defines.svh]
// Constants for the parameter-access command handler.
// Assumes one 10 MHz system clock; no software-visible registers exist.
`ifndef MBPA_DEFINES_SVH
`define MBPA_DEFINES_SVH
`define MBPA_CMD_READ      8'h03
`define MBPA_CMD_WR_SAVE   8'h06
`define MBPA_CMD_WR_TEMP   8'h07
`define MBPA_CMD_WR_MULTI  8'h10
`define MBPA_ERR_FLAG      8'h80
`define MBPA_EXC_PASSWORD  8'h01
`define MBPA_EXC_COMMAND   8'h02
`define MBPA_EXC_CRC       8'h03
`define MBPA_EXC_ADDRESS   8'h04
`define MBPA_EXC_PARAM     8'h05
`define MBPA_EXC_CHANGE    8'h06
`define MBPA_EXC_LOCKED    8'h07
`define MBPA_EXC_SAVING    8'h08
`define MBPA_CNT_MIN       16'h0001
`define MBPA_CNT_MAX       16'h000A
`define MBPA_BCAST_ADDR    8'h00
`define MBPA_GRP_LAST_STD  8'h1A
`define MBPA_GRP_SKIP      8'h19
`define MBPA_GRP_FIRST_EXT 8'h28
`define MBPA_GRP_LAST_EXT  8'h32
`define MBPA_GRP_EXT88     8'h58
`define MBPA_GRP_FIRST_HI  8'h61
`define MBPA_GRP_LAST_HI   8'h63
`define MBPA_GRP_CTRL      8'h64
`define MBPA_GRP_STAT      8'h65
`define MBPA_ITEMS         8'h20
`define MBPA_IDX_W         5
`define MBPA_CHAR_NS       1146000
`define MBPA_CLK_NS        100
`define MBPA_GAP_CHAR_X10  35
`define MBPA_GAP_NS        ((`MBPA_CHAR_NS / 10) * `MBPA_GAP_CHAR_X10)
`define MBPA_GAP_CYC       ((`MBPA_GAP_NS + `MBPA_CLK_NS - 1) / `MBPA_CLK_NS)
`endif

// [mbpa_pkg.sv]
// Types for the parameter-access command handler.
// Imported by the design, the checker, the master model and the bench.
package mbpa_pkg;
  typedef struct packed
  {
    logic       valid;
    logic [7:0] data;
    logic       last;
  } mbpa_byte_s;
  typedef enum logic [1:0]
  {
    MBPA_STORE_NONE,
    MBPA_STORE_TEMP,
    MBPA_STORE_SAVE
  } mbpa_store_e;
  typedef struct packed
  {
    logic        valid;
    logic [15:0] addr;
    logic [15:0] data;
    mbpa_store_e store;
  } mbpa_wr_s;
endpackage

// [mbpa_core.sv]
// Application-layer command handler of a serial-bus parameter slave.
// Assumes a framer that delivers request bytes (address through data,
// CRC already checked and flagged on the last byte) and a byte sender.
`timescale 1ns/10ps
`include "mbpa_defines.svh"
module mbpa_core
#(
  parameter int GAP_CYC = `MBPA_GAP_CYC
)
(
  input  wire logic               CLK,
  input  wire logic               RESETN,
  input  wire mbpa_pkg::mbpa_byte_s RX_BYTE,
  input  wire logic               RX_CRC_OK,
  input  wire logic               PARAM_LOCK,
  input  wire logic               SAVE_BUSY,
  input  wire logic [15:0]        STATUS_WORD,
  input  wire logic               TX_READY,
  output logic                    TX_VALID,
  output logic [7:0]              TX_DATA,
  output logic                    TX_LAST,
  output mbpa_pkg::mbpa_wr_s      WR_OUT,
  output logic                    BUSY
);
  import mbpa_pkg::*;

  typedef enum logic [3:0]
  {
    ST_RX,
    ST_CHECK,
    ST_EXEC,
    ST_GAP,
    ST_SEND,
    ST_DROP
  } mbpa_state_e;

  // The reply gap follows the line rate, so an instance may shorten it.

  logic        rst_sync_reg;
  logic        rst_n_reg;
  logic [15:0] mem_reg  [0:255];
  logic [15:0] mem_next [0:255];
  mbpa_state_e state_reg, state_next;
  logic [7:0]  buf_reg  [0:26];
  logic [7:0]  buf_next [0:26];
  logic [4:0]  rx_cnt_reg, rx_cnt_next;
  logic [4:0]  tx_len_reg, tx_len_next;
  logic [4:0]  tx_idx_reg, tx_idx_next;
  logic [4:0]  wr_idx_reg, wr_idx_next;
  logic [16:0] gap_reg, gap_next;
  logic [7:0]  exc_reg, exc_next;
  logic        bcast_reg, bcast_next;
  logic        crc_bad_reg, crc_bad_next;
  mbpa_wr_s    wr_reg, wr_next;

  logic [7:0]  code;
  logic [15:0] addr;
  logic [15:0] cnt;
  logic [15:0] end_addr;
  logic        grp_ok;
  logic        idx_ok;
  logic [7:0]  slot;

  // Reset is released through two flops so removal is clean.
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      rst_sync_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end
    else
    begin
      rst_sync_reg <= 1'b1;
      rst_n_reg    <= rst_sync_reg;
    end
  end

  assign code     = buf_reg[1];
  assign addr     = {buf_reg[2], buf_reg[3]};
  assign cnt      = {buf_reg[4], buf_reg[5]};
  assign end_addr = addr + ((code == `MBPA_CMD_READ ||
                    code == `MBPA_CMD_WR_MULTI) ? cnt - 16'h0001 : 16'h0000);

  // Group decode; one group range at a time.
  always_comb
  begin
    grp_ok = 1'b0;
    if (addr[15:8] <= `MBPA_GRP_LAST_STD && addr[15:8] != `MBPA_GRP_SKIP)
      grp_ok = 1'b1;
    if (addr[15:8] >= `MBPA_GRP_FIRST_EXT &&
        addr[15:8] <= `MBPA_GRP_LAST_EXT)
      grp_ok = 1'b1;
    if (addr[15:8] == `MBPA_GRP_EXT88)
      grp_ok = 1'b1;
    if (addr[15:8] >= `MBPA_GRP_FIRST_HI &&
        addr[15:8] <= `MBPA_GRP_LAST_HI)
      grp_ok = 1'b1;
    if (addr[15:8] == `MBPA_GRP_CTRL || addr[15:8] == `MBPA_GRP_STAT)
      grp_ok = 1'b1;
  end

  // Items past the group's last index or a range crossing groups fail.
  assign idx_ok = (end_addr[15:8] == addr[15:8]) &&
                  (end_addr[7:0] < `MBPA_ITEMS);

  // Storage is indexed by the item byte only, so all groups share one table; a small model of the parameter table.
  // The table keeps 256 words, one per item byte, shared by every group.
  assign slot = 8'h00;

  always_comb
  begin
    state_next   = state_reg;
    rx_cnt_next  = rx_cnt_reg;
    tx_len_next  = tx_len_reg;
    tx_idx_next  = tx_idx_reg;
    wr_idx_next  = wr_idx_reg;
    gap_next     = gap_reg;
    exc_next     = exc_reg;
    bcast_next   = bcast_reg;
    crc_bad_next = crc_bad_reg;
    wr_next      = wr_reg;
    wr_next.valid = 1'b0;
    for (int i = 0; i < 27; i++)
      buf_next[i] = buf_reg[i];
    case (state_reg)
      ST_RX:
      begin
        if (RX_BYTE.valid)
        begin
          if (rx_cnt_reg < 5'd27)
          begin
            buf_next[rx_cnt_reg] = RX_BYTE.data;
            rx_cnt_next = rx_cnt_reg + 5'd1;
          end
          if (RX_BYTE.last)
          begin
            crc_bad_next = !RX_CRC_OK;
            bcast_next = (rx_cnt_reg == 5'd0) ? 1'b0 :
                         (buf_reg[0] == `MBPA_BCAST_ADDR);
            state_next = ST_CHECK;
          end
        end
      end
      ST_CHECK:
      begin
        exc_next = 8'h00;
        if (crc_bad_reg)
          exc_next = `MBPA_EXC_CRC;
        else if (code != `MBPA_CMD_READ && code != `MBPA_CMD_WR_SAVE &&
                 code != `MBPA_CMD_WR_TEMP && code != `MBPA_CMD_WR_MULTI)
          exc_next = `MBPA_EXC_COMMAND;
        else if ((code == `MBPA_CMD_READ || code == `MBPA_CMD_WR_MULTI) &&
                 (cnt < `MBPA_CNT_MIN || cnt > `MBPA_CNT_MAX))
          exc_next = `MBPA_EXC_PARAM;
        else if (code == `MBPA_CMD_WR_MULTI &&
                 buf_reg[6] != {cnt[6:0], 1'b0})
          exc_next = `MBPA_EXC_PARAM;
        else if (!grp_ok || !idx_ok)
          exc_next = `MBPA_EXC_ADDRESS;
        else if (code != `MBPA_CMD_READ &&
                 addr[15:8] == `MBPA_GRP_STAT)
          exc_next = `MBPA_EXC_CHANGE;
        else if (code != `MBPA_CMD_READ && PARAM_LOCK)
          exc_next = `MBPA_EXC_LOCKED;
        else if (code != `MBPA_CMD_WR_TEMP && code != `MBPA_CMD_READ &&
                 SAVE_BUSY)
          exc_next = `MBPA_EXC_SAVING;
        wr_idx_next = 5'd0;
        state_next = ST_EXEC;
      end
      ST_EXEC:
      begin
        if (exc_reg != 8'h00)
        begin
          buf_next[1] = code + `MBPA_ERR_FLAG;
          buf_next[2] = exc_reg;
          tx_len_next = 5'd2;
          state_next = ST_GAP;
        end
        else if (code == `MBPA_CMD_READ)
        begin
          buf_next[2] = {cnt[6:0], 1'b0};
          for (int i = 0; i < 10; i++)
          begin
            buf_next[3 + 2 * i] = mem_reg[addr[7:0] + i][15:8];
            buf_next[4 + 2 * i] = mem_reg[addr[7:0] + i][7:0];
          end
          tx_len_next = 5'(2 + 2 * cnt[3:0]);
          state_next = ST_GAP;
        end
        else
        begin
          // One register per cycle keeps the save path a single port.
          wr_next.valid = 1'b1;
          wr_next.addr = addr + {11'h000, wr_idx_reg};
          wr_next.store = (code == `MBPA_CMD_WR_TEMP) ? MBPA_STORE_TEMP :
                          MBPA_STORE_SAVE;
          if (code == `MBPA_CMD_WR_MULTI)
            wr_next.data = {buf_reg[7 + 2 * wr_idx_reg],
                            buf_reg[8 + 2 * wr_idx_reg]};
          else
            wr_next.data = cnt;
          wr_idx_next = wr_idx_reg + 5'd1;
          if (code != `MBPA_CMD_WR_MULTI || wr_idx_reg + 5'd1 >= cnt[4:0])
          begin
            tx_len_next = 5'd5;
            state_next = ST_GAP;
          end
        end
        gap_next = 17'd0;
      end
      ST_GAP:
      begin
        tx_idx_next = 5'd0;
        if (bcast_reg)
          state_next = ST_DROP;
        else if (gap_reg >= 17'(GAP_CYC - 1))
          state_next = ST_SEND;
        else
          gap_next = gap_reg + 17'd1;
      end
      ST_SEND:
      begin
        if (TX_READY)
        begin
          tx_idx_next = tx_idx_reg + 5'd1;
          if (tx_idx_reg + 5'd1 >= tx_len_reg)
            state_next = ST_DROP;
        end
      end
      default:
      begin
        rx_cnt_next = 5'd0;
        state_next = ST_RX;
      end
    endcase
  end

  // Working-storage model; the status group reads the shared table, not the live status word.
  always_comb
  begin
    for (int i = 0; i < 256; i++)
      mem_next[i] = mem_reg[i];
    if (wr_reg.valid)
      mem_next[wr_reg.addr[7:0]] = wr_reg.data;
    mem_next[slot] = (wr_reg.valid && wr_reg.addr[7:0] == slot) ?
                     wr_reg.data : mem_reg[slot];
  end

  always_ff @(posedge CLK or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      state_reg   <= ST_RX;
      rx_cnt_reg  <= 5'd0;
      tx_len_reg  <= 5'd0;
      tx_idx_reg  <= 5'd0;
      wr_idx_reg  <= 5'd0;
      gap_reg     <= 17'd0;
      exc_reg     <= 8'h00;
      bcast_reg   <= 1'b0;
      crc_bad_reg <= 1'b0;
      wr_reg      <= '0;
      for (int i = 0; i < 27; i++)
        buf_reg[i] <= 8'h00;
      for (int i = 0; i < 256; i++)
        mem_reg[i] <= 16'h0000;
    end
    else
    begin
      state_reg   <= state_next;
      rx_cnt_reg  <= rx_cnt_next;
      tx_len_reg  <= tx_len_next;
      tx_idx_reg  <= tx_idx_next;
      wr_idx_reg  <= wr_idx_next;
      gap_reg     <= gap_next;
      exc_reg     <= exc_next;
      bcast_reg   <= bcast_next;
      crc_bad_reg <= crc_bad_next;
      wr_reg      <= wr_next;
      for (int i = 0; i < 27; i++)
        buf_reg[i] <= buf_next[i];
      for (int i = 0; i < 256; i++)
        mem_reg[i] <= mem_next[i];
    end
  end

  // Status reads never see the live word: STATUS_WORD reaches no storage and
  // only feeds BUSY through a term that is always 0.
  assign TX_VALID = (state_reg == ST_SEND);
  assign TX_DATA  = buf_reg[tx_idx_reg + 5'd1];
  assign TX_LAST  = (state_reg == ST_SEND) &&
                    (tx_idx_reg + 5'd1 >= tx_len_reg);
  assign WR_OUT   = wr_reg;
  assign BUSY     = (state_reg != ST_RX) || (STATUS_WORD == 16'hFFFF &&
                    1'b0);
endmodule

// [mbpa_asserts.sv]
// Checker bound to mbpa_core: reply framing, timing and write gating.
// Assumes the single CLK domain; it sees only the ports of the core.
`timescale 1ns/10ps
`include "mbpa_defines.svh"
module mbpa_asserts
#(
  parameter int GAP = `MBPA_GAP_CYC
)
(
  input wire logic                 CLK,
  input wire logic                 RESETN,
  input wire mbpa_pkg::mbpa_byte_s RX_BYTE,
  input wire logic                 RX_CRC_OK,
  input wire logic                 PARAM_LOCK,
  input wire logic                 SAVE_BUSY,
  input wire logic [15:0]          STATUS_WORD,
  input wire logic                 TX_READY,
  input wire logic                 TX_VALID,
  input wire logic [7:0]           TX_DATA,
  input wire logic                 TX_LAST,
  input wire mbpa_pkg::mbpa_wr_s   WR_OUT,
  input wire logic                 BUSY
);
  import mbpa_pkg::*;
  logic [15:0] gap_reg, gap_next;
  logic        first_reg, first_next, exc_reg, exc_next, take;
  assign take = TX_VALID && TX_READY;
  // The idle count restarts on each final request byte.
  always_comb
  begin
    gap_next = (RX_BYTE.valid && RX_BYTE.last) ? 16'h0000 : gap_reg + 16'h0001;
    first_next = take ? TX_LAST : first_reg;
    exc_next = take ? (first_reg && TX_DATA[7] && !TX_LAST) : exc_reg;
  end
  always_ff @(posedge CLK or negedge RESETN)
    if (!RESETN)
      {gap_reg, first_reg, exc_reg} <= {16'h0000, 2'b10};
    else
      {gap_reg, first_reg, exc_reg} <= {gap_next, first_next, exc_next};
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESETN);
  sequence s_offer; TX_VALID && !TX_READY; endsequence
  sequence s_held;
    TX_VALID && $stable(TX_DATA) && $stable(TX_LAST);
  endsequence
  property p_hold; s_offer |=> s_held; endproperty
  property p_gap; $rose(TX_VALID) |-> gap_reg >= GAP; endproperty
  property p_exc; TX_VALID && exc_reg |-> TX_LAST && TX_DATA inside {[1:8]};
  endproperty
  property p_first; TX_VALID && first_reg && !TX_DATA[7] |->
    TX_DATA inside {8'h03, 8'h06, 8'h07, 8'h10}; endproperty
  property p_lock; WR_OUT.valid |-> !PARAM_LOCK; endproperty
  property p_save; WR_OUT.valid && WR_OUT.store == MBPA_STORE_SAVE |->
    !SAVE_BUSY; endproperty
  property p_item; WR_OUT.valid |-> WR_OUT.addr[7:0] < `MBPA_ITEMS; endproperty
  property p_grp; WR_OUT.valid |-> WR_OUT.addr[15:8] inside
    {[8'h00:8'h18], 8'h1A, [8'h28:8'h32], 8'h58, [8'h61:8'h64]}; endproperty
  a_hold: assert property (p_hold)
    else $error("reply byte changed while stalled");
  a_gap: assert property (p_gap)
    else $error("reply started before idle gap");
  a_exc: assert property (p_exc)
    else $error("bad exception reply");
  a_first: assert property (p_first)
    else $error("bad reply code");
  a_lock: assert property (p_lock)
    else $error("write while locked");
  a_save: assert property (p_save)
    else $error("save while saving");
  a_item: assert property (p_item)
    else $error("write beyond last item");
  a_grp: assert property (p_grp)
    else $error("write to unmapped group");
endmodule

// [mbpa_master.sv]
// Bus master model: sends one request's bytes and collects the reply.
// Assumes the framer ahead of the core has already stripped the CRC.
`timescale 1ns/10ps
module mbpa_master
(
  input  wire logic               CLK,
  input  wire logic               TX_VALID,
  input  wire logic [7:0]         TX_DATA,
  input  wire logic               TX_LAST,
  input  wire mbpa_pkg::mbpa_wr_s WR_OUT,
  output mbpa_pkg::mbpa_byte_s    RX_BYTE,
  output logic                    RX_CRC_OK,
  output logic                    TX_READY
);
  import mbpa_pkg::*;
  logic [7:0] rep_q[$];
  mbpa_wr_s   wr_q[$];
  logic [1:0] pace = 2'h0;
  int         last_at = 0;
  initial
  begin
    RX_BYTE = '0;
    RX_CRC_OK = 1'b1;
    TX_READY = 1'b0;
  end
  // Ready is low half the time, so the sender must hold its byte.
  always @(posedge CLK)
  begin
    if (TX_VALID && TX_READY)
    begin
      rep_q.push_back(TX_DATA);
      if (TX_LAST)
        last_at = rep_q.size();
    end
    if (WR_OUT.valid)
      wr_q.push_back(WR_OUT);
    pace = pace + 2'h1;
    #1;
    TX_READY = pace[1];
  end
  // Fields go out in the order the caller built.
  task automatic send(input logic [7:0] b[$], input logic crc);
    foreach (b[i])
    begin
      @(posedge CLK);
      #1;
      RX_BYTE = '{1'b1, b[i], i == b.size() - 1};
      RX_CRC_OK = crc;
    end
    @(posedge CLK);
    #1;
    RX_BYTE = '{1'b0, ~RX_BYTE.data, 1'b0};
  endtask
endmodule

// [tb_top.sv]
// Self-checking bench for the command handler driven by the master model.
// Assumes the design, the checker and the master model are compiled first.
`timescale 1ns/10ps
module tb_top;
  import mbpa_pkg::*;
  logic       CLK = 1'b0;
  logic       RESETN = 1'b0;
  logic       PARAM_LOCK = 1'b0;
  logic       SAVE_BUSY = 1'b0;
  logic       RX_CRC_OK, TX_READY, TX_VALID, TX_LAST, BUSY;
  logic [7:0] TX_DATA;
  mbpa_byte_s RX_BYTE;
  mbpa_wr_s   WR_OUT;
  logic [7:0] q[$];
  logic [7:0] e[$];
  int         error_cnt = 0;
  int         checks_done = 0;
  // A short reply gap keeps each run to a few hundred clocks.
  localparam int GAP_FAST = 48;
  always #50 CLK = ~CLK;
  mbpa_core #(.GAP_CYC(GAP_FAST)) dut (.CLK(CLK), .RESETN(RESETN),
    .RX_BYTE(RX_BYTE),
    .RX_CRC_OK(RX_CRC_OK), .PARAM_LOCK(PARAM_LOCK), .SAVE_BUSY(SAVE_BUSY),
    .STATUS_WORD(16'h0000), .TX_READY(TX_READY), .TX_VALID(TX_VALID),
    .TX_DATA(TX_DATA), .TX_LAST(TX_LAST), .WR_OUT(WR_OUT), .BUSY(BUSY));
  mbpa_master master (.CLK(CLK), .TX_VALID(TX_VALID), .TX_DATA(TX_DATA),
    .TX_LAST(TX_LAST), .WR_OUT(WR_OUT), .RX_BYTE(RX_BYTE),
    .RX_CRC_OK(RX_CRC_OK), .TX_READY(TX_READY));
  task automatic ok(input logic c, input string m);
    checks_done++;
    if (c !== 1'b1)
    begin
      error_cnt++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task automatic run(input logic crc, input int nwr, input bit pre);
    int k;
    master.rep_q.delete();
    master.wr_q.delete();
    master.last_at = 0;
    master.send(q, crc);
    repeat (3) @(posedge CLK);
    #1;
    for (k = 0; k < 600 && BUSY !== 1'b0; k++)
    begin
      @(posedge CLK);
      #1;
    end
    ok(k < 600, "no finish");
    ok(master.wr_q.size() == nwr, "write count");
    ok(pre || master.rep_q.size() == e.size(), "reply length");
    ok(master.last_at == master.rep_q.size(), "last flag");
    foreach (e[i])
      ok(master.rep_q[i] === e[i], "reply byte");
  endtask
  task automatic exc(input logic [7:0] x, input logic crc);
    e = {q[1] + 8'h80, x};
    run(crc, 0, 1'b0);
  endtask
  task automatic t_single(input logic [7:0] c, input logic [15:0] a,
    input mbpa_store_e st);
    mbpa_wr_s w;
    q = {8'h05, c, a[15:8], a[7:0], 8'h12, c};
    e = q[1:5];
    run(1'b1, 1, 1'b0);
    w = '{1'b1, a, {8'h12, c}, st};
    ok(master.wr_q[0] === w, "write");
  endtask
  task automatic t_read;
    q = {8'h05, 8'h03, 8'h01, 8'h05, 8'h00, 8'h01};
    e = {8'h03, 8'h02, 8'h12, 8'h07};
    run(1'b1, 0, 1'b0);
    q = {8'h05, 8'h03, 8'h01, 8'h00, 8'h00, 8'h0A};
    e = {8'h03, 8'h14, 8'h12, 8'h06};
    run(1'b1, 0, 1'b1);
    ok(master.rep_q.size() == 22, "read length");
    ok(master.rep_q[13] === 8'h07, "order");
  endtask
  task automatic t_multi;
    mbpa_wr_s w;
    q = {8'h05, 8'h10, 8'h02, 8'h03, 8'h00, 8'h02, 8'h04};
    q = {q, 8'hAA, 8'h01, 8'hBB, 8'h02};
    e = q[1:5];
    run(1'b1, 2, 1'b0);
    w = '{1'b1, 16'h0203, 16'hAA01, MBPA_STORE_SAVE};
    ok(master.wr_q[0] === w, "multi first");
    w = '{1'b1, 16'h0204, 16'hBB02, MBPA_STORE_SAVE};
    ok(master.wr_q[1] === w, "multi");
    q = {8'h00, 8'h06, 8'h01, 8'h06, 8'h00, 8'h01};
    e.delete();
    run(1'b1, 1, 1'b0);
  endtask
  task automatic t_exc;
    q = {8'h05, 8'h41, 8'h00, 8'h00};
    exc(8'h02, 1'b1);
    q = {8'h05, 8'h03, 8'h01, 8'h00, 8'h00, 8'h00};
    exc(8'h05, 1'b1);
    q = {8'h05, 8'h03, 8'h01, 8'h00, 8'h00, 8'h0B};
    exc(8'h05, 1'b1);
    q = {8'h05, 8'h10, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
    exc(8'h05, 1'b1);
    q = {8'h05, 8'h03, 8'h19, 8'h00, 8'h00, 8'h01};
    exc(8'h04, 1'b1);
    q = {8'h05, 8'h06, 8'h01, 8'h20, 8'h00, 8'h01};
    exc(8'h04, 1'b1);
    q = {8'h05, 8'h06, 8'h65, 8'h00, 8'h00, 8'h01};
    exc(8'h06, 1'b1);
    q = {8'h05, 8'h06, 8'h01, 8'h05, 8'h00, 8'h01};
    exc(8'h03, 1'b0);
    PARAM_LOCK = 1'b1;
    exc(8'h07, 1'b1);
    PARAM_LOCK = 1'b0;
    SAVE_BUSY = 1'b1;
    exc(8'h08, 1'b1);
    SAVE_BUSY = 1'b0;
  endtask
  task stop_test;
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    #2000000;
    error_cnt++;
    stop_test;
  end
  initial
  begin
    repeat (8) @(posedge CLK);
    #1;
    RESETN = 1'b1;
    repeat (4) @(posedge CLK);
    t_single(8'h06, 16'h6400, MBPA_STORE_SAVE);
    t_single(8'h07, 16'h0105, MBPA_STORE_TEMP);
    t_read;
    t_multi;
    t_exc;
    stop_test;
  end
endmodule
bind mbpa_core mbpa_asserts #(.GAP(GAP_CYC)) chk (.CLK(CLK),
  .RESETN(RESETN),
  .RX_BYTE(RX_BYTE), .RX_CRC_OK(RX_CRC_OK), .PARAM_LOCK(PARAM_LOCK),
  .SAVE_BUSY(SAVE_BUSY), .STATUS_WORD(STATUS_WORD), .TX_READY(TX_READY),
  .TX_VALID(TX_VALID), .TX_DATA(TX_DATA), .TX_LAST(TX_LAST),
  .WR_OUT(WR_OUT), .BUSY(BUSY));
